/* dv/rbl_boot_partner.sv */
// Far side of the boot loader: a serial flash answering one read, or a
// two-wire EEPROM. Assumes the bench resolves the shared pin and fills img.
`timescale 1ns/1ps
module rbl_boot_partner (
    input  wire logic        rstn,
    input  wire logic        flash_cs_n,
    input  wire logic        flash_clk,
    input  wire logic        dio,
    input  wire logic        flash_on,
    input  wire logic        ee_on,
    input  wire logic [31:0] flash_word,
    output logic             flash_di = 1'b0,
    output logic             m_oe = 1'b0,
    output logic             m_o = 1'b0,
    output logic             ee_low = 1'b0
);
    logic [7:0]  img [512];
    logic [31:0] hdr;
    logic [7:0]  sh;
    logic [8:0]  ptr = 9'h000;
    int          fc = 0;
    int          bc = 0;
    int          nb = 0;
    logic        rd = 1'b0;
    logic        act = 1'b0;
    always @(negedge flash_cs_n) fc = 0;
    // Released data in falls to the board pull-down
    always @(posedge flash_cs_n)
    begin
        m_oe = 1'b0;
        flash_di = 1'b0;
    end
    always @(posedge flash_clk)
        if (flash_on && !flash_cs_n)
        begin
            if (fc < 32) hdr = {hdr[30:0], dio};
            fc++;
        end
    // Data moves on the falling edge so it is steady when sampled
    always @(negedge flash_clk)
        if (flash_on && !flash_cs_n)
        begin
            m_oe = hdr[31:24] == 8'h3b && fc >= 40 && fc < 56;
            if (m_oe) {flash_di, m_o} = flash_word[2*(55-fc) +: 2];
            else if (hdr[31:24] == 8'h03 && fc >= 32 && fc < 64)
                flash_di = flash_word[63-fc];
        end
    always @(negedge dio)
        // Bus start only counts while the flash is deselected
        if (ee_on && flash_clk && flash_cs_n)
        begin
            act = 1'b1;
            bc = 0;
            nb = 0;
            rd = 1'b0;
        end
    always @(posedge dio) if (flash_clk) act = 1'b0;
    always @(posedge flash_clk)
        if (act)
        begin
            if (bc < 8) sh = {sh[6:0], dio};
            else if (rd && dio) act = 1'b0;
            bc++;
        end
    always @(negedge flash_clk or negedge rstn)
        if (!rstn)
        begin
            act = 1'b0;
            ee_low = 1'b0;
        end
        else if (act)
        begin
            if (bc == 8 && !rd)
            begin
                ee_low = 1'b1;
                rd = nb == 0 && sh[0];
                if (nb == 1) ptr = {1'b0, sh};
                nb++;
            end
            else if (bc == 8)
            begin
                ee_low = 1'b0;
                ptr++;
            end
            else if (bc == 9)
            begin
                bc = 0;
                ee_low = rd && !img[ptr][7];
            end
            else if (rd) ee_low = !img[ptr][7-bc];
        end
endmodule : rbl_boot_partner

/* dv/tb_rom_boot_config_loader.sv */
// Bench for the boot loader: boots with flash, EEPROM or nothing fitted.
// Assumes the partner model and a board pull-up that also sets the strap.
`timescale 1ns/1ps
`include "rbl_cfg.svh"
`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) \
        begin \
            miscompares++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_rom_boot_config_loader;
    localparam logic [31:0] SIG1 = "ata2";
    localparam logic [31:0] SIG2 = "ecf1";
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, flt = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000, fetch_addr;
    logic [31:0] pwdata = 32'h0, prdata, q, flash_word = 32'h0;
    logic        pready, pslverr, flash_cs_n, flash_clk, flash_di, dio_i;
    logic        dio_o, dio_oe_n, dio_pd_en, ext_code_en, card_oe_n;
    logic        card_ie, boot_done, m_oe, m_o, ee_low, err;
    logic        board_up = 1'b0, flash_on = 1'b0, ee_on = 1'b0;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    // Strong board pull-up beats the weak pull-down; with neither and no driver, the pin floats
    assign dio_i = !dio_oe_n ? dio_o : m_oe ? m_o : ee_low ? 1'b0 :
                   board_up ? 1'b1 : dio_pd_en ? 1'b0 : flt;
    rbl_boot_loader #(.FAST_DIV(1), .SLOW_DIV(2)) dut (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_cs_n, .flash_clk, .flash_di,
        .dio_i, .dio_o, .dio_oe_n, .dio_pd_en, .ext_code_en, .fetch_addr,
        .card_oe_n, .card_ie, .boot_done);
    rbl_boot_partner u_part (
        .rstn(presetn), .flash_cs_n, .flash_clk, .dio(dio_i), .flash_on,
        .ee_on, .flash_word, .flash_di, .m_oe, .m_o, .ee_low);
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        flt <= ~flt;
        cyc++;
        if (cyc == 98000)
        begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude;
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [15:0] a, input logic [31:0] x,
                      input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, q)
    endtask : rd
    task automatic cfg(input logic [8:0] a, input logic [7:0] x);
        apb(1'b1, `RBL_CFGA_ADDR, {23'h0, a});
        rd(`RBL_CFGD_ADDR, {24'h0, x}, "cfg_byte");
    endtask : cfg
    task automatic boot(input logic up, input logic fon,
                        input logic [31:0] w, input logic eon);
        int n;
        n = 0;
        @(posedge pclk);
        presetn <= 1'b0;
        board_up <= up;
        flash_on <= fon;
        flash_word <= w;
        ee_on <= eon;
        repeat (10) @(posedge pclk);
        `CHK("pad_float", 2'b11, {dio_oe_n, dio_pd_en})
        `CHK("card_reset", 2'b10, {card_oe_n, card_ie})
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("pad_release", 2'b00, {dio_oe_n, dio_pd_en})
        while (boot_done !== 1'b1 && n < 60000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("boot_done", 1'b1, boot_done)
    endtask : boot
    task automatic t_flash_ok;
        boot(1'b0, 1'b1, "2DFU", 1'b0);
        `CHK("probe", {8'h3b, 24'h00fffa}, u_part.hdr)
        `CHK("ext_code", 1'b1, ext_code_en)
        `CHK("fetch", 16'h0000, fetch_addr)
        `CHK("card_on", 2'b01, {card_oe_n, card_ie})
        rd(`RBL_CTL_ADDR, 32'h02, "ctl_reset");
        rd(`RBL_STAT_ADDR, 32'h07, "status");
        apb(1'b1, `RBL_CTL_ADDR, 32'h07);
        rd(`RBL_CTL_ADDR, 32'h06, "ctl_rw");
        `CHK("clk_idle", 1'b1, flash_clk)
        apb(1'b0, 16'h2410, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, q})
    endtask : t_flash_ok
    task automatic t_flash_bad;
        boot(1'b0, 1'b1, 32'h12345678, 1'b0);
        `CHK("ext_code", 1'b0, ext_code_en)
        rd(`RBL_STAT_ADDR, 32'h05, "status");
        cfg(9'h0fc, 8'hff);
    endtask : t_flash_bad
    // A damaged second mark must keep the built-in configuration
    task automatic t_eeprom(input logic good);
        for (int i = 0; i < 512; i++) u_part.img[i] = i[7:0] ^ 8'h5a;
        for (int k = 0; k < 4; k++)
        begin
            u_part.img[9'h0fc + k] = SIG1[31-8*k -: 8];
            u_part.img[9'h17c + k] = SIG2[31-8*k -: 8];
        end
        u_part.img[9'h17f][0] = good;
        boot(1'b1, 1'b0, 32'h0, 1'b1);
        rd(`RBL_CTL_ADDR, 32'h03, "ctl_fast");
        `CHK("ext_code", 1'b0, ext_code_en)
        rd(`RBL_STAT_ADDR, good ? 32'h19 : 32'h11, "status");
        for (int i = 0; i < 512; i++)
            cfg(i[8:0], good ? u_part.img[i] : 8'hff);
    endtask : t_eeprom
    task automatic t_none;
        // Bus pull-up fitted, so the missing EEPROM answers with a NACK
        boot(1'b1, 1'b0, 32'h0, 1'b0);
        `CHK("ext_code", 1'b0, ext_code_en)
        rd(`RBL_STAT_ADDR, 32'h01, "status");
        cfg(9'h000, 8'hff);
    endtask : t_none
    initial
    begin
        t_flash_ok();
        t_flash_bad();
        t_eeprom(1'b1);
        t_eeprom(1'b0);
        t_none();
        conclude();
    end
endmodule : tb_rom_boot_config_loader

/* hw/rbl_boot_loader.sv */
// Boot loader: strap capture, serial flash probe, two-wire EEPROM load.
// Assumes a single clock, APB software access, and pad logic that
// resolves the shared data pin from its enable and pull-down.
// Contract
// - After reset, read four flash bytes from 0xFFFA, check firmware mark
// - Valid flash mark enables external code, fetch starts at 0x0000
// - Without a valid flash mark, execution stays in internal ROM
// - No flash found: probe EEPROM marks at FCh-FFh and 17Ch-17Fh
// - EEPROM marks present: load contents as the active configuration
// - No external store: built-in default configuration is used
// - During reset the shared data pin floats with pull-down on
// - At release latch strap, drop pull-down, pin returns to data out
// - Strap high selects the fast flash clock; board holds it high
// - Control register at 0x2400 reports rate, resets to 0x02
// - Flash reads work in single-bit and dual-bit data modes
// - Flash clock idle level suits both mode 0 and mode 3 parts
// - Media card pins keep drivers and input buffers off in reset
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "rbl_cfg.svh"
module rbl_boot_loader
    import rbl_pkg::*;
#(
    parameter int         FAST_DIV = 1,
    parameter int         SLOW_DIV = 8,
    parameter logic [7:0] DEF_BYTE = 8'hff
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             flash_cs_n,
    output logic             flash_clk,
    input  wire logic        flash_di,
    input  wire logic        dio_i,
    output logic             dio_o,
    output logic             dio_oe_n,
    output logic             dio_pd_en,
    output logic             ext_code_en,
    output logic      [15:0] fetch_addr,
    output logic             card_oe_n,
    output logic             card_ie,
    output logic             boot_done
);
    rbl_state_t  st;
    logic        strap;
    logic        ph;
    logic [1:0]  q;
    logic [5:0]  cnt;
    logic [1:0]  wb;
    logic [31:0] sh;
    logic [31:0] rx;
    logic [8:0]  ee_idx;
    logic [7:0]  div;
    logic        scl;
    logic        ee_fail;
    logic        sig_bad;
    logic        ee_ok;
    logic        flash_found;
    logic        dual;
    logic        cpol;
    logic [8:0]  cfg_addr;
    logic [7:0]  mem_rdata;
    localparam logic [7:0] CTL_RST = `RBL_CTL_RESET;

    wire        in_ee    = st inside {ST_E_START, ST_E_WR, ST_E_RD,
                                      ST_E_STOP};
    wire        flash_st = st inside {ST_F_CMD, ST_F_DUMMY, ST_F_DATA};
    // EEPROM always runs slow; flash rate follows the strap
    wire [7:0]  div_load = (in_ee || !strap) ? 8'(SLOW_DIV - 1)
                                             : 8'(FAST_DIV - 1);
    wire        tick     = (div == 8'h00);
    wire        step     = ce && tick;
    wire        rise     = step && !ph;
    wire        fall     = step && ph;
    wire        q3       = step && (q == 2'd3);
    wire        bit_end  = q3 && (cnt == 6'd8);
    wire        ee_last  = (ee_idx == `RBL_EE_LAST);
    wire [1:0]  k        = ee_idx[1:0];
    wire [31:0] sig_sel  = (ee_idx[8:2] == `RBL_SIG1_WORD) ? `RBL_SIG_EE1
                                                          : `RBL_SIG_EE2;
    wire [7:0]  sig_byte = 8'(sig_sel >> {3'(2'd3 - k), 3'd0});
    wire        in_sig   = (ee_idx[8:2] == `RBL_SIG1_WORD)
                        || (ee_idx[8:2] == `RBL_SIG2_WORD);
    wire        mem_we   = (st == ST_E_RD) && bit_end;
    wire [5:0]  data_end = dual ? 6'd15 : 6'd31;
    // Dual reads interleave the flash output line into the odd bits
    wire        di_seen  = |(rx & (dual ? 32'haaaa_aaaa : 32'hffff_ffff));
    wire [31:0] flash_hdr = {(dual ? `RBL_CMD_DREAD : `RBL_CMD_READ),
                             `RBL_FLASH_SIG_ADDR};

    // Outside the EEPROM states the clock idles at the chosen polarity while chip select is high
    assign flash_clk  = in_ee ? scl : (flash_cs_n ? cpol : ph);
    assign dio_o      = in_ee ? 1'b0 : sh[31];
    assign fetch_addr = `RBL_FETCH_BASE;
    assign boot_done  = (st == ST_DONE);
    // Card pads stay dead until boot ends, so no glitch reaches a card
    assign card_oe_n  = !boot_done;
    assign card_ie    = boot_done;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div <= 8'h00;
        else if (ce)
            div <= tick ? div_load : div - 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st          <= ST_STRAP;
            strap       <= 1'b0;
            dio_oe_n    <= 1'b1;    // Floating pin in reset
            dio_pd_en   <= 1'b1;    // Pull-down holds strap low
            flash_cs_n  <= 1'b1;
            ph          <= 1'b0;
            q           <= 2'd0;
            cnt         <= 6'd0;
            wb          <= 2'd0;
            sh          <= 32'h0000_0000;
            rx          <= 32'h0000_0000;
            ee_idx      <= 9'h000;
            scl         <= 1'b1;
            ee_fail     <= 1'b0;
            sig_bad     <= 1'b0;
            ee_ok       <= 1'b0;
            flash_found <= 1'b0;
            ext_code_en <= 1'b0;
        end
        else if (ce)
        begin
            unique case (st)
                ST_STRAP:
                begin
                    strap      <= dio_i;
                    dio_pd_en  <= 1'b0;
                    dio_oe_n   <= 1'b0;
                    flash_cs_n <= 1'b0;
                    sh         <= flash_hdr;
                    st         <= ST_F_CMD;
                end
                ST_F_CMD, ST_F_DUMMY:
                begin
                    if (rise)
                        ph <= 1'b1;
                    if (fall)
                    begin
                        ph  <= 1'b0;
                        sh  <= {sh[30:0], 1'b0};
                        cnt <= cnt + 6'd1;
                        if (st == ST_F_CMD && cnt == 6'd31)
                        begin
                            cnt <= 6'd0;
                            // Dual reads hand the pin to the flash
                            dio_oe_n <= dual;
                            st <= dual ? ST_F_DUMMY : ST_F_DATA;
                        end
                        if (st == ST_F_DUMMY && cnt == 6'd7)
                        begin
                            cnt <= 6'd0;
                            st  <= ST_F_DATA;
                        end
                    end
                end
                ST_F_DATA:
                begin
                    dio_oe_n <= 1'b1;
                    if (rise)
                    begin
                        ph <= 1'b1;
                        rx <= dual ? {rx[29:0], flash_di, dio_i}
                                   : {rx[30:0], flash_di};
                    end
                    if (fall)
                    begin
                        ph  <= 1'b0;
                        cnt <= cnt + 6'd1;
                        if (cnt == data_end)
                        begin
                            flash_cs_n <= 1'b1;
                            st         <= ST_F_EVAL;
                        end
                    end
                end
                ST_F_EVAL:
                begin
                    // Only the flash output line counts: the shared pin
                    // carries the bus pull-up and reads ones when unfitted
                    flash_found <= di_seen;
                    if (rx == `RBL_SIG_FLASH)
                    begin
                        ext_code_en <= 1'b1;
                        st          <= ST_DONE;
                    end
                    else if (di_seen)
                        st <= ST_DONE;
                    else
                    begin
                        q   <= 2'd0;
                        wb  <= 2'd0;
                        st  <= ST_E_START;
                    end
                end
                ST_E_START:
                begin
                    if (step)
                        q <= q + 2'd1;
                    if (step && q == 2'd0)
                        dio_oe_n <= 1'b1;
                    if (step && q == 2'd1)
                        scl <= 1'b1;
                    if (step && q == 2'd2)
                        dio_oe_n <= 1'b0;
                    if (q3)
                    begin
                        scl <= 1'b0;
                        cnt <= 6'd0;
                        sh  <= {(wb == 2'd0) ? `RBL_EE_DEV_WR
                                             : `RBL_EE_DEV_RD, 24'h000000};
                        st  <= ST_E_WR;
                    end
                end
                ST_E_WR, ST_E_RD:
                begin
                    if (step)
                        q <= q + 2'd1;
                    if (step && q == 2'd0)
                    begin
                        if (st == ST_E_WR)
                            dio_oe_n <= (cnt == 6'd8) ? 1'b1 : sh[31];
                        else
                            dio_oe_n <= (cnt == 6'd8) ? ee_last : 1'b1;
                    end
                    if (step && q == 2'd1)
                        scl <= 1'b1;
                    if (step && q == 2'd2)
                    begin
                        if (st == ST_E_RD && cnt != 6'd8)
                            rx <= {rx[30:0], dio_i};
                        if (st == ST_E_WR && cnt == 6'd8 && dio_i)
                            ee_fail <= 1'b1;
                    end
                    if (q3)
                    begin
                        scl <= 1'b0;
                        cnt <= cnt + 6'd1;
                        sh  <= {sh[30:0], 1'b0};
                    end
                    if (bit_end)
                    begin
                        cnt <= 6'd0;
                        if (st == ST_E_WR)
                        begin
                            wb <= wb + 2'd1;
                            sh <= {`RBL_EE_WADDR, 24'h000000};
                            if (ee_fail)
                                st <= ST_E_STOP;
                            else if (wb == 2'd1)
                                st <= ST_E_START;
                            else if (wb == 2'd2)
                                st <= ST_E_RD;
                        end
                        else
                        begin
                            // Signature bytes checked as they stream
                            if (in_sig && rx[7:0] != sig_byte)
                                sig_bad <= 1'b1;
                            ee_idx <= ee_idx + 9'h001;
                            if (ee_last)
                                st <= ST_E_STOP;
                        end
                    end
                end
                ST_E_STOP:
                begin
                    if (step)
                        q <= q + 2'd1;
                    if (step && q == 2'd0)
                        dio_oe_n <= 1'b0;
                    if (step && q == 2'd1)
                        scl <= 1'b1;
                    if (step && q == 2'd2)
                        dio_oe_n <= 1'b1;
                    if (q3)
                    begin
                        ee_ok <= !ee_fail && !sig_bad;
                        st    <= ST_DONE;
                    end
                end
                ST_DONE:
                    dio_oe_n <= 1'b1;
            endcase
        end
    end

    rbl_cfg_mem #(
        .AW (9),
        .DW (8)
    ) u_mem (
        .pclk  (pclk),
        .ce    (ce),
        .we    (mem_we),
        .waddr (ee_idx),
        .wdata (rx[7:0]),
        .raddr (cfg_addr),
        .rdata (mem_rdata)
    );

    // Software sees the loaded image only when its marks were good
    wire [7:0]  cfg_byte = ee_ok ? mem_rdata : DEF_BYTE;
    wire [7:0]  ctl_val  = {5'd0, cpol, dual, strap};
    wire [7:0]  stat_val = {3'd0, !ee_fail && st == ST_DONE && !flash_found,
                            ee_ok, flash_found, ext_code_en, boot_done};
    wire        hit_ctl  = (paddr == `RBL_CTL_ADDR);
    wire        hit_stat = (paddr == `RBL_STAT_ADDR);
    wire        hit_cfga = (paddr == `RBL_CFGA_ADDR);
    wire        hit_cfgd = (paddr == `RBL_CFGD_ADDR);
    wire        hit      = hit_ctl | hit_stat | hit_cfga | hit_cfgd;
    wire        setup    = psel && !penable;
    wire        wr_acc   = psel && penable && pwrite;
    wire [7:0]  rd_mux   = hit_ctl  ? ctl_val
                         : hit_stat ? stat_val
                         : hit_cfga ? cfg_addr[7:0]
                         : hit_cfgd ? cfg_byte : 8'h00;
    wire        rd_hi    = hit_cfga && cfg_addr[8];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Read data is latched in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce && setup)
            prdata <= {23'd0, rd_hi, rd_mux};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dual     <= CTL_RST[`RBL_CTL_DUAL_BIT];
            cpol     <= CTL_RST[`RBL_CTL_CPOL_BIT];
            cfg_addr <= 9'h000;
        end
        else if (ce && wr_acc)
        begin
            if (hit_ctl)
            begin
                dual <= pwdata[`RBL_CTL_DUAL_BIT];
                cpol <= pwdata[`RBL_CTL_CPOL_BIT];
            end
            if (hit_cfga)
                cfg_addr <= pwdata[8:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_strap_float;
        st == ST_STRAP |-> dio_oe_n && dio_pd_en;
    endproperty
    a_strap_float: assert property (p_strap_float)
        else $error("shared pin not floating before strap capture");

    property p_strap_latch;
        // Sampled reset keeps the release edge itself out of the check
        presetn && st == ST_STRAP && ce
            |=> !dio_pd_en && strap == $past(dio_i);
    endproperty
    a_strap_latch: assert property (p_strap_latch)
        else $error("strap not latched or pull-down left on");

    property p_probe_addr;
        presetn && st == ST_STRAP && ce |=> sh[23:0] == `RBL_FLASH_SIG_ADDR;
    endproperty
    a_probe_addr: assert property (p_probe_addr)
        else $error("flash probe address wrong");

    property p_ext_code;
        st == ST_F_EVAL && ce && rx == `RBL_SIG_FLASH
            |=> ext_code_en && fetch_addr == `RBL_FETCH_BASE;
    endproperty
    a_ext_code: assert property (p_ext_code)
        else $error("valid flash mark did not enable external code");

    property p_int_rom;
        st == ST_F_EVAL && ce && rx != `RBL_SIG_FLASH |=> !ext_code_en;
    endproperty
    a_int_rom: assert property (p_int_rom)
        else $error("external code enabled without a valid mark");

    sequence s_no_flash;
        st == ST_F_EVAL && ce && !di_seen;
    endsequence
    property p_ee_probe;
        s_no_flash |=> st == ST_E_START ##[1:64] st == ST_E_WR;
    endproperty
    a_ee_probe: assert property (p_ee_probe)
        else $error("EEPROM probe not started after empty flash");

    property p_slow_rate;
        flash_st && !strap && step |=> !tick;
    endproperty
    a_slow_rate: assert property (p_slow_rate)
        else $error("low strap did not slow the flash clock");

    property p_idle_clk;
        flash_cs_n && !in_ee |-> flash_clk == cpol;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("flash clock idle level wrong");

    property p_dual_pin;
        st == ST_F_DUMMY |=> dio_oe_n;
    endproperty
    a_dual_pin: assert property (p_dual_pin)
        else $error("data pin still driven in dual read");

    property p_card_off;
        !boot_done |-> card_oe_n && !card_ie;
    endproperty
    a_card_off: assert property (p_card_off)
        else $error("card pads enabled before boot end");

    property p_ctl_read;
        setup && ce && !pwrite && hit_ctl |=> prdata[7:0] == $past(ctl_val);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control register read wrong");
endmodule : rbl_boot_loader

/* hw/rbl_cfg.svh */
// Offsets, field positions, reset values and constants of the boot loader.
// Assumes byte addresses on a 16-bit APB address bus.
`ifndef RBL_CFG_SVH
`define RBL_CFG_SVH
`define RBL_CTL_ADDR       16'h2400
`define RBL_STAT_ADDR      16'h2404
`define RBL_CFGA_ADDR      16'h2408
`define RBL_CFGD_ADDR      16'h240c
`define RBL_CTL_RESET      8'h02
`define RBL_CTL_SPEED_BIT  0
`define RBL_CTL_DUAL_BIT   1
`define RBL_CTL_CPOL_BIT   2
`define RBL_SIG_FLASH      32'h32444655
`define RBL_SIG_EE1        32'h61746132
`define RBL_SIG_EE2        32'h65636631
`define RBL_FLASH_SIG_ADDR 24'h00fffa
`define RBL_FETCH_BASE     16'h0000
`define RBL_CMD_READ       8'h03
`define RBL_CMD_DREAD      8'h3b
`define RBL_SIG1_WORD      7'h3f
`define RBL_SIG2_WORD      7'h5f
`define RBL_EE_LAST        9'h1ff
`define RBL_EE_DEV_WR      8'ha0
`define RBL_EE_DEV_RD      8'ha1
`define RBL_EE_WADDR       8'h00
`endif

/* hw/rbl_cfg_mem.sv */
// Configuration image memory, one write and one registered read port.
// Assumes a single clock and a clock enable that freezes it.
`timescale 1ns/1ps
module rbl_cfg_mem #(
    parameter int AW = 9,
    parameter int DW = 8
)(
    input  wire logic          pclk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge pclk)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule : rbl_cfg_mem

/* hw/rbl_pkg.sv */
// Types shared by the boot loader files.
// Assumes nothing beyond the compile order.
package rbl_pkg;
    typedef enum logic [3:0] {
        ST_STRAP, ST_F_CMD, ST_F_DUMMY, ST_F_DATA, ST_F_EVAL,
        ST_E_START, ST_E_WR, ST_E_RD, ST_E_STOP, ST_DONE
    } rbl_state_t;
endpackage : rbl_pkg
